// ===== hw/pdc_port_cfg.sv
// Purpose: pin configuration of an 8-bit port: analog select, pull-ups, input level
// Assumes: APB slave, one wait state, 25 MHz pclk
// Notes:   pad controls all leave flip-flops
//
// The APB register port is this design's own decision.
module pdc_port_cfg
	import pdc_pkg::*;
#(
	parameter int NPINS = 8
)(
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	// Pads
	input  wire logic [7:0]  pad_in,
	output pdc_pad_ctl_t     pad_ctl,
	output logic      [7:0]  pin_direction
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] pdc_zext8(input logic [7:0] v);
		pdc_zext8 = {24'h000000, v};
	endfunction

	function automatic logic pdc_hit(input logic [11:0] a);
		pdc_hit = (a == PDC_OFF_LEVEL) || (a == PDC_OFF_ANALOG) || (a == PDC_OFF_PULLUP) ||
			(a == PDC_OFF_DIR) || (a == PDC_OFF_OPTION) || (a == PDC_OFF_PINS);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	// Configuration registers
	logic [7:0]   level_q, level_d;
	logic [2:0]   analog_select_bits_q, analog_select_bits_d;
	logic [7:0]   pullup_q, pullup_d;
	logic [7:0]   dir_q, dir_d;
	logic         global_pullup_off_q, global_pullup_off_d;
	// Bus answer
	logic         pready_q, pready_d;
	logic         pslverr_q, pslverr_d;
	logic [31:0]  prdata_q, prdata_d;
	// Pad side
	pdc_pad_ctl_t pad_q, pad_d;
	logic [7:0]   dir_out_q, dir_out_d;
	// Decode
	logic [7:0]   pins_sync;
	logic [7:0]   analog_mask;
	logic [7:0]   pins_digital;
	logic         access;
	logic         wr_access;
	logic         rd_access;

	// Pins are asynchronous, so two stages first
	pdc_sync #(.WIDTH(8)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (pad_in),
		.sync_out (pins_sync)
	);

	assign analog_mask  = {5'h00, analog_select_bits_q};
	assign pins_digital = pins_sync & ~analog_mask;
	// Pready guard stops a second commit in the answer cycle
	assign access       = psel && penable && !pready_q;
	assign wr_access    = access && pwrite;
	assign rd_access    = access && !pwrite;

	// ----------------------------------------
	// Register next state
	// ----------------------------------------
	always_comb
	begin
		level_d              = level_q;
		analog_select_bits_d = analog_select_bits_q;
		pullup_d             = pullup_q;
		dir_d                = dir_q;
		global_pullup_off_d  = global_pullup_off_q;
		if (wr_access)
		begin
			case (paddr)
				PDC_OFF_LEVEL:
				begin
					level_d = pwdata[7:0];
				end
				PDC_OFF_ANALOG:
				begin
					analog_select_bits_d = pwdata[PDC_NUM_ANALOG-1:0];
				end
				PDC_OFF_PULLUP:
				begin
					pullup_d = pwdata[7:0];
				end
				PDC_OFF_DIR:
				begin
					dir_d = pwdata[7:0];
				end
				PDC_OFF_OPTION:
				begin
					global_pullup_off_d = pwdata[PDC_GPOFF_BIT];
				end
				// Pins word and unmapped words ignore writes
				default:
				begin
					level_d = level_q;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Bus answer next state
	// ----------------------------------------
	always_comb
	begin
		// Answer registered from the first access cycle: one wait state
		pready_d  = access;
		pslverr_d = access && !pdc_hit(paddr);
		prdata_d  = 32'h00000000;
		if (rd_access)
		begin
			case (paddr)
				PDC_OFF_LEVEL:  prdata_d = pdc_zext8(level_q);
				PDC_OFF_ANALOG: prdata_d = pdc_zext8(analog_mask);
				PDC_OFF_PULLUP: prdata_d = pdc_zext8(pullup_q);
				PDC_OFF_DIR:    prdata_d = pdc_zext8(dir_q);
				PDC_OFF_OPTION: prdata_d = pdc_zext8({global_pullup_off_q, 7'h00});
				PDC_OFF_PINS:   prdata_d = pdc_zext8(pins_digital);
				default:        prdata_d = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// Pad control next state
	// ----------------------------------------
	always_comb
	begin
		dir_out_d       = dir_q;
		pad_d.level_sel = level_q;
		pad_d.analog_on = analog_mask;
		// digital buffer off when analog; on otherwise
		pad_d.in_buf_en = ~analog_mask;
		// global off wins; outputs lose pull-up
		// direction is software's, not forced here
		pad_d.pullup_on = global_pullup_off_q ? 8'h00 : (pullup_q & dir_q);
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Configuration
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			level_q              <= PDC_RST_LEVEL;
			analog_select_bits_q <= PDC_RST_ANALOG;
			pullup_q             <= PDC_RST_PULLUP;
			dir_q                <= PDC_RST_DIR;
			global_pullup_off_q  <= PDC_RST_GPOFF;
		end
		else
		begin
			level_q              <= level_d;
			analog_select_bits_q <= analog_select_bits_d;
			pullup_q             <= pullup_d;
			dir_q                <= dir_d;
			global_pullup_off_q  <= global_pullup_off_d;
		end
	end

	// Bus answer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end
		else
		begin
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
		end
	end

	// Pad outputs, so every pad control leaves a flip-flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pad_q     <= PDC_RST_PAD;
			dir_out_q <= PDC_RST_DIR;
		end
		else
		begin
			pad_q     <= pad_d;
			dir_out_q <= dir_out_d;
		end
	end

	assign pready        = pready_q;
	assign pslverr       = pslverr_q;
	assign prdata        = prdata_q;
	assign pad_ctl       = pad_q;
	assign pin_direction = dir_out_q;

endmodule // pdc_port_cfg

// ===== hw/pdc_pkg.sv
// Purpose: constants and types for the port pin configuration block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   byte address of a register is four times its index
package pdc_pkg;

	// ----------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------
	localparam logic [9:0]  PDC_IDX_LEVEL  = 10'h38F;
	localparam logic [9:0]  PDC_IDX_ANALOG = 10'h390;
	localparam logic [9:0]  PDC_IDX_PULLUP = 10'h391;
	localparam logic [9:0]  PDC_IDX_DIR    = 10'h392;
	localparam logic [9:0]  PDC_IDX_OPTION = 10'h393;
	localparam logic [9:0]  PDC_IDX_PINS   = 10'h394;
	localparam logic [11:0] PDC_OFF_LEVEL  = {PDC_IDX_LEVEL, 2'h0};
	localparam logic [11:0] PDC_OFF_ANALOG = {PDC_IDX_ANALOG, 2'h0};
	localparam logic [11:0] PDC_OFF_PULLUP = {PDC_IDX_PULLUP, 2'h0};
	localparam logic [11:0] PDC_OFF_DIR    = {PDC_IDX_DIR, 2'h0};
	localparam logic [11:0] PDC_OFF_OPTION = {PDC_IDX_OPTION, 2'h0};
	localparam logic [11:0] PDC_OFF_PINS   = {PDC_IDX_PINS, 2'h0};

	// ----------------------------------------
	// Reset values and field layout
	// ----------------------------------------
	localparam logic [7:0] PDC_RST_LEVEL  = 8'hFF;
	localparam logic [2:0] PDC_RST_ANALOG = 3'h7;
	localparam logic [7:0] PDC_RST_PULLUP = 8'hFF;
	localparam logic [7:0] PDC_RST_DIR    = 8'hFF;
	localparam logic       PDC_RST_GPOFF  = 1'b1;
	localparam int         PDC_GPOFF_BIT  = 7;
	localparam int         PDC_NUM_ANALOG = 3;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] pullup_on;
		logic [7:0] in_buf_en;
		logic [7:0] analog_on;
		logic [7:0] level_sel;
	} pdc_pad_ctl_t;

	// Pad controls during reset: pull-ups off, lower three pins analog
	localparam pdc_pad_ctl_t PDC_RST_PAD = '{pullup_on: 8'h00, in_buf_en: 8'hF8, analog_on: 8'h07, level_sel: 8'hFF};

endpackage

// ===== hw/pdc_sync.sv
// Purpose: two-stage synchroniser for pin levels
// Assumes: inputs are asynchronous to pclk
// Notes:   first stage is read only by the second
module pdc_sync
	import pdc_pkg::*;
#(
	parameter int WIDTH = 8
)(
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule // pdc_sync

// ===== verif/pdc_port_cfg_asserts.sv
// Purpose: port checks for pdc_port_cfg
// Assumes: pad_ctl follows a register write within two edges
// Notes:   bound at foot
module pdc_port_cfg_chk
	import pdc_pkg::*;
(
	input wire logic         pclk,
	input wire logic         presetn,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic [11:0]  paddr,
	input wire logic [31:0]  pwdata,
	input wire logic         pready,
	input wire logic [31:0]  prdata,
	input wire logic         pslverr,
	input wire logic [7:0]   pad_in,
	input wire pdc_pad_ctl_t pad_ctl,
	input wire logic [7:0]   pin_direction
);
	logic wr;
	logic rd;
	assign wr = psel && penable && pready && pwrite;
	assign rd = psel && penable && pready && !pwrite;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_ANA_SET: assert property (wr && paddr == PDC_OFF_ANALOG |-> ##2
		pad_ctl.analog_on[2:0] == $past(pwdata[2:0], 2)) else $error("analog select not applied");
	AST_BUF_EN: assert property (pad_ctl.in_buf_en == ~pad_ctl.analog_on) else $error("input buffer wrong");
	AST_ANA_HI: assert property (rd && paddr == PDC_OFF_ANALOG |-> prdata[31:3] == 29'h0) else $error("upper bits");
	AST_PU_BIT: assert property (wr && paddr == PDC_OFF_PULLUP |-> ##2
		(pad_ctl.pullup_on & ~$past(pwdata[7:0], 2)) == 8'h00) else $error("pull-up bit ignored");
	AST_PU_OFF: assert property (wr && paddr == PDC_OFF_OPTION && pwdata[7] |-> ##2
		pad_ctl.pullup_on == 8'h00) else $error("global pull-up off ignored");
	AST_PU_OUT: assert property ((pad_ctl.pullup_on & ~pin_direction) == 8'h00) else $error("pull-up on output");
	AST_PIN_AN: assert property (rd && paddr == PDC_OFF_PINS |->
		(prdata[7:0] & pad_ctl.analog_on) == 8'h00) else $error("analog pin reads one");
endmodule // pdc_port_cfg_chk

bind pdc_port_cfg pdc_port_cfg_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.pad_in(pad_in), .pad_ctl(pad_ctl), .pin_direction(pin_direction));

// ===== verif/pdc_port_cfg_test.sv
// Purpose: self-checking bench for pdc_port_cfg
// Assumes: APB slave answers within a few cycles
// Notes:   waits are bounded so a hang ends the run
module pdc_port_cfg_test
	import pdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]  paddr = 12'h000;
	logic [31:0]  pwdata = 32'h0, rd, prdata;
	logic [7:0]   pad_in = 8'hFF, pin_direction;
	logic         pready, pslverr, err;
	pdc_pad_ctl_t pad_ctl;
	int           num_errors = 0, comparisons = 0;
	always #20 pclk = ~pclk;
	pdc_port_cfg dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.pad_in(pad_in), .pad_ctl(pad_ctl), .pin_direction(pin_direction));
	task automatic stop_test();
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	// Request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 9);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			num_errors++;
			stop_test();
		end
		@(posedge pclk);
	endtask
	task automatic t_reset();
		chk("pad", pad_ctl, 32'h00F807FF);
		apb(1'b0, PDC_OFF_LEVEL, 32'h0);
		chk("level", rd, 32'h000000FF);
		apb(1'b0, PDC_OFF_PULLUP, 32'h0);
		chk("pullup", rd, 32'h000000FF);
		apb(1'b1, PDC_OFF_LEVEL, 32'h0000003C);
		chk("lsel", {24'h0, pad_ctl.level_sel}, 32'h0000003C);
	endtask
	task automatic t_analog();
		apb(1'b1, PDC_OFF_DIR, 32'h000000FF);
		apb(1'b1, PDC_OFF_ANALOG, 32'hFFFFFFFA);
		apb(1'b0, PDC_OFF_ANALOG, 32'h0);
		chk("analog", rd, 32'h00000002);
		chk("abuf", {16'h0, pad_ctl.analog_on, pad_ctl.in_buf_en}, 32'h000002FD);
		apb(1'b0, PDC_OFF_PINS, 32'h0);
		chk("pins", rd, 32'h000000FD);
		pad_in <= 8'h0F;
		repeat (3) @(posedge pclk);
		apb(1'b0, PDC_OFF_PINS, 32'h0);
		chk("pins_low", rd, 32'h0000000D);
	endtask
	task automatic t_pullup();
		apb(1'b1, PDC_OFF_DIR, 32'h0F);
		apb(1'b1, PDC_OFF_PULLUP, 32'hA5);
		apb(1'b1, PDC_OFF_OPTION, 32'h0);
		@(posedge pclk);
		chk("pull", {24'h0, pad_ctl.pullup_on}, 32'h00000005);
		chk("dir", {24'h0, pin_direction}, 32'h0000000F);
		apb(1'b1, PDC_OFF_OPTION, 32'h80);
		@(posedge pclk);
		chk("gpoff", {24'h0, pad_ctl.pullup_on}, 32'h00000000);
	endtask
	task automatic t_unmapped();
		apb(1'b0, 12'h3A4, 32'h0);
		chk("uerr", {31'h0, err}, 32'h1);
		chk("udata", rd, 32'h0);
	endtask
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_analog();
		t_pullup();
		t_unmapped();
		stop_test();
	end
endmodule // pdc_port_cfg_test
